// file: inc/cswc_pkg.sv
/*
 * package for the cpu sleep and wakeup controller: cpu count, sleep states,
 * per-cpu request and status carriers.
 * assumes one clock domain; nothing else.
 */
`default_nettype none

package cswc_pkg;
	localparam int NUM_CPU = 2;
	localparam int SCR_DEEP_BIT = 2; // deep_sleep_select position in cpu_system_control_reg
	localparam int SCR_WIDTH = 3;
	localparam logic [SCR_WIDTH-1:0] SCR_RESET = 3'h0;

	typedef enum logic [1:0] {
		CSWC_ACTIVE,
		CSWC_LIGHT,
		CSWC_DEEP
	} cswc_state_t;

	// per-cpu request from the core pipeline, one-cycle pulses
	typedef struct packed {
		logic wfi;
		logic wfe;
		logic sev;
	} cswc_req_t;

	// per-cpu status
	typedef struct packed {
		logic halted;
		logic deep;
		logic event_latched;
	} cswc_stat_t;
endpackage

`default_nettype wire

// file: core/cswc_ctrl.sv
/*
 * cpu sleep and wakeup controller: per-cpu sleep state machine, event
 * latches for set-event, and the system deep sleep condition.
 * assumes instruction pulses and irq lines from same-clock logic; irq and
 * wake-enable vectors are synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module cswc_ctrl #(
	parameter int NUM_CPU = cswc_pkg::NUM_CPU,
	parameter int NUM_IRQ = 8
) (
	input wire logic clk_i, // 40 MHz clock
	input wire logic rst_i, // synchronous reset, active high
	input wire logic ce_i, // clock enable, freezes state when low
	input wire cswc_pkg::cswc_req_t [NUM_CPU-1:0] req_i, // sleep/event instruction pulses
	input wire logic [NUM_CPU-1:0][cswc_pkg::SCR_WIDTH-1:0] scr_i, // cpu_system_control_reg
	input wire logic [NUM_IRQ-1:0] irq_i, // peripheral interrupt lines
	input wire logic [NUM_IRQ-1:0] wake_en_i, // interrupts enabled as wakeup sources from wfe sleep; wfi sleep wakes on any irq line
	output logic [NUM_CPU-1:0] run_o, // cpu may execute
	output cswc_pkg::cswc_stat_t [NUM_CPU-1:0] stat_o, // per-cpu status
	output logic sys_deep_sleep_o // whole device in deep sleep
);
	// ****************************************
	// parameter checks
	// ****************************************
	// set-event needs a peer, and the wake
	// reduction needs at least one line
	generate
		if (NUM_CPU < 2) begin : g_bad_cpu
			$error("cswc_ctrl: needs at least two cpus");
		end
		if (NUM_IRQ < 1) begin : g_bad_irq
			$error("cswc_ctrl: needs at least one irq line");
		end
	endgenerate

	// ****************************************
	// helper functions
	// ****************************************
	// set-event seen by cpu self: from any other cpu, never itself
	function automatic logic others_sev(input cswc_pkg::cswc_req_t [NUM_CPU-1:0] r, input int self);
		logic s;
		s = 1'b0;
		for (int j = 0; j < NUM_CPU; j++) begin
			if (j != self && r[j].sev)
				s = 1'b1;
		end
		return s;
	endfunction

	// sleep depth picked by the control word of the instruction cycle
	function automatic cswc_pkg::cswc_state_t sleep_depth(input logic [cswc_pkg::SCR_WIDTH-1:0] ctl);
		cswc_pkg::cswc_state_t d;
		if (ctl[cswc_pkg::SCR_DEEP_BIT])
			d = cswc_pkg::CSWC_DEEP;
		else
			d = cswc_pkg::CSWC_LIGHT;
		return d;
	endfunction

	// light or deep, both halt the cpu
	function automatic logic is_asleep(input cswc_pkg::cswc_state_t s);
		logic a;
		a = s == cswc_pkg::CSWC_LIGHT || s == cswc_pkg::CSWC_DEEP;
		return a;
	endfunction

	// ****************************************
	// declarations
	// ****************************************
	// wake sources
	logic any_irq; // any interrupt line high
	logic wake_irq; // an enabled wakeup source high
	logic [NUM_CPU-1:0] sev_in; // set-event from a peer

	// per-cpu decode
	logic [NUM_CPU-1:0] skip_req; // wfe with event already latched
	logic [NUM_CPU-1:0] sleep_req; // sleep instruction accepted
	logic [NUM_CPU-1:0] wake_now; // sleeping cpu resumes this edge

	// per-cpu sleep state
	cswc_pkg::cswc_state_t state [NUM_CPU];
	cswc_pkg::cswc_state_t next_state [NUM_CPU];
	logic [NUM_CPU-1:0] by_wfe; // sleep entered by wait-for-event
	logic [NUM_CPU-1:0] next_by_wfe;

	// event latches
	logic [NUM_CPU-1:0] evt;
	logic [NUM_CPU-1:0] next_evt;

	// system deep sleep
	logic sys_deep;
	logic next_sys_deep;

	// ****************************************
	// wake sources
	// ****************************************
	always_comb begin
		any_irq = |irq_i;
		wake_irq = |(irq_i & wake_en_i);
		for (int i = 0; i < NUM_CPU; i++) begin
			sev_in[i] = others_sev(req_i, i);
		end
	end

	// ****************************************
	// per-cpu decode
	// ****************************************
	// wfi and wfe together act as wfi
	always_comb begin
		for (int i = 0; i < NUM_CPU; i++) begin
			skip_req[i] = !is_asleep(state[i]) && req_i[i].wfe && !req_i[i].wfi && evt[i];
			sleep_req[i] = !is_asleep(state[i]) && (req_i[i].wfi || req_i[i].wfe) && !skip_req[i];
			if (!is_asleep(state[i]))
				wake_now[i] = 1'b0;
			else if (by_wfe[i])
				wake_now[i] = evt[i] || sev_in[i] || wake_irq;
			else
				wake_now[i] = any_irq || wake_irq;
		end
	end

	// ****************************************
	// per-cpu sleep state
	// ****************************************
	always_comb begin
		for (int i = 0; i < NUM_CPU; i++) begin
			next_state[i] = state[i];
			next_by_wfe[i] = by_wfe[i];
			case (state[i])
				cswc_pkg::CSWC_ACTIVE: begin
					if (sleep_req[i]) begin
						next_by_wfe[i] = !req_i[i].wfi;
						next_state[i] = sleep_depth(scr_i[i]);
					end
				end
				cswc_pkg::CSWC_LIGHT, cswc_pkg::CSWC_DEEP: begin
					// further sleep pulses are ignored here
					if (wake_now[i]) begin
						next_state[i] = cswc_pkg::CSWC_ACTIVE;
						next_by_wfe[i] = 1'b0;
					end
				end
				default: begin
					next_state[i] = cswc_pkg::CSWC_ACTIVE;
					next_by_wfe[i] = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NUM_CPU; i++)
				state[i] <= cswc_pkg::CSWC_ACTIVE;
			by_wfe <= '0;
		end else if (ce_i) begin
			state <= next_state;
			by_wfe <= next_by_wfe;
		end
	end

	// ****************************************
	// event latches
	// ****************************************
	// consumed by a skipped wfe or a wfe wake;
	// a latched event meeting a new set-event stays set
	always_comb begin
		for (int i = 0; i < NUM_CPU; i++) begin
			if (skip_req[i] || (wake_now[i] && by_wfe[i]))
				next_evt[i] = evt[i] && sev_in[i];
			else
				next_evt[i] = evt[i] || sev_in[i];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt <= '0;
		end else if (ce_i) begin
			evt <= next_evt;
		end
	end

	// ****************************************
	// system deep sleep
	// ****************************************
	// taken from next states so it moves on the
	// same edge as the last cpu entering deep sleep
	always_comb begin
		next_sys_deep = 1'b1;
		for (int i = 0; i < NUM_CPU; i++) begin
			if (next_state[i] != cswc_pkg::CSWC_DEEP)
				next_sys_deep = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sys_deep <= 1'b0;
		end else if (ce_i) begin
			sys_deep <= next_sys_deep;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// decoded straight from the state registers
	always_comb begin
		for (int i = 0; i < NUM_CPU; i++) begin
			run_o[i] = state[i] == cswc_pkg::CSWC_ACTIVE;
			stat_o[i].halted = is_asleep(state[i]);
			stat_o[i].deep = state[i] == cswc_pkg::CSWC_DEEP;
			stat_o[i].event_latched = evt[i];
		end
		sys_deep_sleep_o = sys_deep;
	end
endmodule

`default_nettype wire

// file: tb/cswc_chk.sv
/* port checker for cswc_ctrl, bound below; one clock, idle while ce_i is low. */
`timescale 1ns/1ps
`default_nettype none
module cswc_chk #(parameter int NUM_CPU = 2, parameter int NUM_IRQ = 8) (
	input wire logic clk_i, // clk
	input wire logic rst_i, // rst
	input wire logic ce_i, // clock enable
	input wire cswc_pkg::cswc_req_t [NUM_CPU-1:0] req_i, // req
	input wire logic [NUM_CPU-1:0][2:0] scr_i, // ctl
	input wire logic [NUM_IRQ-1:0] irq_i, // irq
	input wire logic [NUM_IRQ-1:0] wake_en_i, // wen
	input wire logic [NUM_CPU-1:0] run_o, // run
	input wire cswc_pkg::cswc_stat_t [NUM_CPU-1:0] stat_o, // st
	input wire logic sys_deep_sleep_o // sd
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i || !ce_i);
	a_wfi_sleep: assert property (run_o[0] && req_i[0].wfi
		|=> !run_o[0] && stat_o[0].deep == $past(scr_i[0][2])) else $error("entry");
	a_sleep_hold: assert property (!run_o[0] && !irq_i && !req_i[1].sev && !stat_o[0].event_latched
		|=> !run_o[0]) else $error("hold");
	a_irq_wake: assert property (!run_o[0] && |(irq_i & wake_en_i) |=> run_o[0]) else $error("wake");
	a_sev_latch: assert property (run_o[0] && req_i[1].sev && !req_i[0].wfe
		|=> stat_o[0].event_latched) else $error("sev");
	a_no_self: assert property (!stat_o[0].event_latched && !req_i[1].sev
		|=> !stat_o[0].event_latched) else $error("self");
	a_latch_skip: assert property (run_o[0] && stat_o[0].event_latched && req_i[0].wfe && !req_i[0].wfi
		&& !req_i[1].sev |=> run_o[0] && !stat_o[0].event_latched) else $error("skip");
	a_sys_deep: assert property (sys_deep_sleep_o == (stat_o[0].deep && stat_o[1].deep)) else $error("sys");
	a_cpu_indep: assert property (run_o[1] && !req_i[1].wfi && !req_i[1].wfe |=> run_o[1]) else $error("cpu1");
endmodule
bind cswc_ctrl cswc_chk #(.NUM_CPU(NUM_CPU), .NUM_IRQ(NUM_IRQ)) u_chk (.*);
`default_nettype wire

// file: tb/cswc_peer.sv
/* peer: one cpu's pulses and its irq sources; caller runs just past an edge. */
`timescale 1ns/1ps
`default_nettype none
module cswc_peer (
	input wire logic clk_i, // clk
	output var logic [7:0] irq_o, // irq
	output var logic [7:0] en_o, // wake en
	output var cswc_pkg::cswc_req_t req_o // pulses
);
	initial {irq_o, en_o, req_o} = 19'h00000;
	task drive(input logic [7:0] v, e, input logic [2:0] p, input int n);
		{irq_o, en_o, req_o} = {v, e, p};
		repeat (n) @(posedge clk_i);
		#1;
		{irq_o, req_o} = 11'h000;
	endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
/* bench: two peers drive cpu pulses and irqs; ce_i held high except low for one step in t_hold. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, d;
	logic [1:0] r;
	logic [1:0][2:0] s = 6'h00;
	logic [7:0] q0, q1, w0, w1;
	cswc_pkg::cswc_req_t a, b;
	cswc_pkg::cswc_stat_t [1:0] t;
	int n_mismatch = 0, cmp_count = 0;
	cswc_peer p0(.clk_i, .irq_o(q0), .en_o(w0), .req_o(a));
	cswc_peer p1(.clk_i, .irq_o(q1), .en_o(w1), .req_o(b));
	cswc_ctrl dut(.clk_i, .rst_i, .ce_i, .req_i({b, a}), .scr_i(s), .irq_i(q0 | q1),
		.wake_en_i(w0 | w1), .run_o(r), .stat_o(t), .sys_deep_sleep_o(d));
	initial forever #12.5 clk_i = ~clk_i;
	task results;
		if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task st(input int c, input logic [2:0] p, input logic [7:0] v, e, input int n, input logic [8:0] x);
		if (c == 0) p0.drive(v, e, p, n);
		else p1.drive(v, e, p, n);
		cmp_count++;
		if ({r, d, t} !== x) begin
			n_mismatch++;
			$display("[ERR] %0t %h %h", $time, {r, d, t}, x);
		end
	endtask
	task t_sleep;
		s = 6'h04;
		st(0, 3'h4, 8'h00, 8'h00, 1, 9'h106);
		st(0, 3'h0, 8'h01, 8'h00, 2, 9'h180);
		s = 6'h00;
		st(0, 3'h2, 8'h00, 8'h00, 1, 9'h104);
		st(0, 3'h0, 8'h02, 8'h00, 2, 9'h104);
		st(1, 3'h1, 8'h00, 8'h00, 1, 9'h180);
		st(0, 3'h2, 8'h00, 8'h00, 1, 9'h104);
		st(0, 3'h0, 8'h04, 8'h04, 1, 9'h180);
	endtask
	task t_event;
		st(1, 3'h1, 8'h00, 8'h00, 1, 9'h181);
		st(0, 3'h1, 8'h00, 8'h00, 1, 9'h189);
		st(0, 3'h2, 8'h00, 8'h00, 1, 9'h188);
		s = 6'h24;
		st(1, 3'h2, 8'h00, 8'h00, 1, 9'h180);
		st(1, 3'h4, 8'h00, 8'h00, 1, 9'h0b0);
		st(0, 3'h4, 8'h00, 8'h00, 1, 9'h076);
		st(1, 3'h0, 8'h80, 8'h80, 1, 9'h180);
	endtask
	task t_hold;
		ce_i = 1'h0;
		st(0, 3'h4, 8'h00, 8'h00, 1, 9'h180);
		ce_i = 1'h1;
		st(0, 3'h0, 8'h00, 8'h00, 1, 9'h180);
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		#1;
		rst_i = 1'h0;
		st(0, 3'h0, 8'h00, 8'h00, 0, 9'h180);
		t_sleep;
		t_event;
		t_hold;
		results;
	end
	initial begin
		#20us;
		n_mismatch++;
		results;
	end
endmodule
`default_nettype wire
